/* logic/pin_test_pkg.sv */
package pin_test_pkg;
	localparam int unsigned NUM_CHAINS   = 12;
	localparam int unsigned CHAIN0_WIDTH = 60;
	localparam int unsigned CHAIN1_WIDTH = 33;
	localparam int unsigned CHAIN2_WIDTH = 44;
	localparam int unsigned CHAIN3_WIDTH = 41;
	localparam int unsigned CHAIN_MAX    = 64;
	localparam logic [1:0]  MODE_FULL    = 2'h0;
	localparam logic [1:0]  MODE_CHAN_A  = 2'h1;
	localparam logic [1:0]  MODE_CHAN_B  = 2'h2;
	localparam logic        ENABLE_RESET = 1'h0;
	typedef enum logic [1:0] {
		ST_HOLD = 2'b01,
		ST_TEST = 2'b10
	} pin_test_state_t;
endpackage : pin_test_pkg

/* logic/xor_tree_pin_test.sv */
`timescale 1ns/1ns
// What this block does
// - Twelve separate parity chains, numbered 0 to 11, each with one result bit.
// - Full-width mode drives each result onto both channel A and B pins.
// - Shared mode shows result on channel A pin in A mode, B pin in B mode.
// - Chains 0-7 use test pins; chains 8-11 reuse host bus pins.
// - Graphics strobe halves feed different chains; other strobe pairs share one.
// - Chain 0 folds 60 inputs.
// - Chain 1 folds 33 inputs.
// - Chain 2 folds 44 inputs.
// - Chain 3 folds 41 inputs.
// - Each chain is a series of two-input XORs, one pin each: parity.
// - Observation pins stay undriven until external reset has been released; chain_result_out is not gated.
module xor_tree_pin_test #(
	parameter int unsigned CHAIN4_WIDTH  = 40,
	parameter int unsigned CHAIN5_WIDTH  = 44,
	parameter int unsigned CHAIN6_WIDTH  = 40,
	parameter int unsigned CHAIN7_WIDTH  = 45,
	parameter int unsigned CHAIN8_WIDTH  = 40,
	parameter int unsigned CHAIN9_WIDTH  = 40,
	parameter int unsigned CHAIN10_WIDTH = 40,
	parameter int unsigned CHAIN11_WIDTH = 40
) (
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	// Test entry
	input  wire logic        external_reset_in_n_in,
	input  wire logic [1:0]  chan_mode_in,
	// Chain pins, chain n in bits [64n +: width_n]
	input  wire logic [767:0] chain_pins_in,
	// Observation pins, bit n is chain n
	output logic [11:0]      chain_result_out,
	output logic [11:0]      obs_chan_a_out,
	output logic [11:0]      obs_chan_b_out,
	output logic [11:0]      obs_chan_a_oe_b_out,
	output logic [11:0]      obs_chan_b_oe_b_out,
	output logic             test_active_out
);
	typedef struct packed {
		pin_test_pkg::pin_test_state_t st;
	} state_t;

	localparam int unsigned WIDTHS [12] = '{pin_test_pkg::CHAIN0_WIDTH,
		pin_test_pkg::CHAIN1_WIDTH, pin_test_pkg::CHAIN2_WIDTH, pin_test_pkg::CHAIN3_WIDTH,
		CHAIN4_WIDTH, CHAIN5_WIDTH, CHAIN6_WIDTH, CHAIN7_WIDTH,
		CHAIN8_WIDTH, CHAIN9_WIDTH, CHAIN10_WIDTH, CHAIN11_WIDTH};

	state_t state_r;
	state_t state_nxt;
	logic   active;

	// Reset release only gates the pin drivers; parity never passes a flop
	always_comb begin
		state_nxt = state_r;
		case (state_r.st)
			pin_test_pkg::ST_HOLD: begin
				if (external_reset_in_n_in) state_nxt.st = pin_test_pkg::ST_TEST;
			end
			pin_test_pkg::ST_TEST: begin
				if (!external_reset_in_n_in) state_nxt.st = pin_test_pkg::ST_HOLD;
			end
			default: state_nxt.st = pin_test_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) state_r.st <= pin_test_pkg::ST_HOLD;
		else state_r <= state_nxt;
	end

	assign active          = (state_r.st == pin_test_pkg::ST_TEST);
	assign test_active_out = active;

	genvar g;
	generate
		for (g = 0; g < pin_test_pkg::NUM_CHAINS; g++) begin : gen_chain
			logic [pin_test_pkg::CHAIN_MAX-1:0] link;
			// Ripple of two-input gates keeps one pin per stage, as board test expects
			assign link[0] = chain_pins_in[g*64];
			for (genvar k = 1; k < pin_test_pkg::CHAIN_MAX; k++) begin : gen_link
				if (k < WIDTHS[g]) begin : gen_use
					assign link[k] = link[k-1] ^ chain_pins_in[g*64+k];
				end else begin : gen_pass
					assign link[k] = link[k-1];
				end
			end
			// Widths fixed for chains 0-3
			assign chain_result_out[g] = link[pin_test_pkg::CHAIN_MAX-1];
			assign obs_chan_a_out[g]   = link[pin_test_pkg::CHAIN_MAX-1];
			assign obs_chan_b_out[g]   = link[pin_test_pkg::CHAIN_MAX-1];
			assign obs_chan_a_oe_b_out[g] = !(active &&
				(chan_mode_in != pin_test_pkg::MODE_CHAN_B));
			assign obs_chan_b_oe_b_out[g] = !(active &&
				(chan_mode_in != pin_test_pkg::MODE_CHAN_A));
		end
	endgenerate

	// Drivers lag the reset pin by one edge, so quiet is checked on the next edge
	chk_hold_quiet: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		!external_reset_in_n_in |=>
		obs_chan_a_oe_b_out == 12'hfff)
		else $error("channel A driven while reset held");

	chk_hold_quiet_b: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		!external_reset_in_n_in |=>
		obs_chan_b_oe_b_out == 12'hfff)
		else $error("channel B driven while reset held");

	chk_full_both: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		active && chan_mode_in == pin_test_pkg::MODE_FULL |->
		obs_chan_a_oe_b_out == 12'h000 && obs_chan_b_oe_b_out == 12'h000)
		else $error("full mode not driving both channels");

	// The spare mode code falls back to full width rather than leaving pins floating
	chk_spare_full: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		active && chan_mode_in == 2'h3 |->
		obs_chan_a_oe_b_out == 12'h000 && obs_chan_b_oe_b_out == 12'h000)
		else $error("spare mode not driving both channels");

	chk_pins_equal: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		obs_chan_a_out == obs_chan_b_out)
		else $error("channel values differ");

	chk_mode_a_only: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		active && chan_mode_in == pin_test_pkg::MODE_CHAN_A |->
		obs_chan_b_oe_b_out == 12'hfff && obs_chan_a_oe_b_out == 12'h000)
		else $error("channel A mode wrong drivers");

	chk_mode_b_only: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		active && chan_mode_in == pin_test_pkg::MODE_CHAN_B |->
		obs_chan_a_oe_b_out == 12'hfff && obs_chan_b_oe_b_out == 12'h000)
		else $error("channel B mode wrong drivers");

	chk_parity_c0: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		chain_result_out[0] == ^chain_pins_in[59:0])
		else $error("chain 0 parity wrong");

	chk_parity_c1: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		chain_result_out[1] == ^chain_pins_in[96:64])
		else $error("chain 1 parity wrong");

	chk_parity_c2: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		chain_result_out[2] == ^chain_pins_in[171:128])
		else $error("chain 2 parity wrong");

	chk_parity_c3: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		chain_result_out[3] == ^chain_pins_in[232:192])
		else $error("chain 3 parity wrong");

	// A single pin flip must show at once; a register stage would hide it a cycle
	chk_toggle_flip: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		$stable(chain_pins_in[767:1]) && $changed(chain_pins_in[0]) |->
		$changed(chain_result_out[0]))
		else $error("chain 0 did not follow its pin");

	chk_release_on: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		$rose(external_reset_in_n_in) ##1 external_reset_in_n_in |->
		active)
		else $error("test not active after release");

	chk_active_follow: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		external_reset_in_n_in |=>
		active)
		else $error("test not active while reset released");

	chk_result_copy: assert property (
		@(posedge mclk_in) disable iff (!rst_b_in)
		chain_result_out == obs_chan_a_out)
		else $error("result port differs from observation pins");

	// Upper pins of a short chain are masked off; a leak would flip parity silently
	genvar c;
	generate
		for (c = 0; c < pin_test_pkg::NUM_CHAINS; c++) begin : gen_chk
			localparam logic [63:0] USED = (64'h1 << WIDTHS[c]) - 64'h1;

			chk_chain_parity: assert property (
				@(posedge mclk_in) disable iff (!rst_b_in)
				chain_result_out[c] == ^(chain_pins_in[c*64 +: 64] & USED))
				else $error("chain parity wrong");

			chk_chain_copy: assert property (
				@(posedge mclk_in) disable iff (!rst_b_in)
				obs_chan_a_out[c] == chain_result_out[c] &&
				obs_chan_b_out[c] == chain_result_out[c])
				else $error("observation pin not showing chain result");

			chk_chain_quiet: assert property (
				@(posedge mclk_in) disable iff (!rst_b_in)
				!active |->
				obs_chan_a_oe_b_out[c] && obs_chan_b_oe_b_out[c])
				else $error("observation pin driven before release");
		end
	endgenerate

	cov_full: cover property (@(posedge mclk_in)
		active && chan_mode_in == pin_test_pkg::MODE_FULL);
	cov_a: cover property (@(posedge mclk_in)
		active && chan_mode_in == pin_test_pkg::MODE_CHAN_A);
	cov_b: cover property (@(posedge mclk_in)
		active && chan_mode_in == pin_test_pkg::MODE_CHAN_B);
	cov_rel: cover property (@(posedge mclk_in) $rose(active));
	cov_flip: cover property (@(posedge mclk_in)
		$stable(chain_pins_in[767:1]) && $changed(chain_pins_in[0]));
endmodule : xor_tree_pin_test

/* test/pin_tester_model.sv */
`timescale 1ns/1ns
module pin_tester_model (
	input  wire logic mclk_in,
	input  wire logic start_in,
	output logic      power_good_out = 1'h0,
	output logic      external_reset_in_n_out = 1'h0
);
	logic [2:0] cnt_r = 3'h0;
	// Power-good first, reset release later, as a tester sequences entry
	// entry straps are not modelled; parity chains do not depend on them
	always @(posedge mclk_in) begin
		if (!start_in) begin
			cnt_r <= 3'h0;
			power_good_out <= 1'h0;
			external_reset_in_n_out <= 1'h0;
		end else begin
			if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
			power_good_out <= (cnt_r >= 3'h2);
			external_reset_in_n_out <= power_good_out && (cnt_r >= 3'h5);
		end
	end
endmodule : pin_tester_model

/* test/xor_tree_pin_test_bench.sv */
`timescale 1ns/1ns
module xor_tree_pin_test_bench;
	logic mclk_in = 1'h0, rst_b_in = 1'h0, start = 1'h0, ext_n, act;
	logic [1:0] mode = 2'h0;
	logic [767:0] pins = '0;
	logic [11:0] res, oa, ob, oea, oeb, ea, eb;
	int failures = 0, comparisons = 0;
	int unsigned w [12] = '{pin_test_pkg::CHAIN0_WIDTH, pin_test_pkg::CHAIN1_WIDTH,
		pin_test_pkg::CHAIN2_WIDTH, pin_test_pkg::CHAIN3_WIDTH, 40, 44, 40, 45, 40, 40, 40, 40};
	initial forever #10 mclk_in = ~mclk_in;
	pin_tester_model u_pin_tester_model (.mclk_in(mclk_in), .start_in(start),
		.power_good_out(), .external_reset_in_n_out(ext_n));
	xor_tree_pin_test u_xor_tree_pin_test (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
		.external_reset_in_n_in(ext_n), .chan_mode_in(mode), .chain_pins_in(pins),
		.chain_result_out(res), .obs_chan_a_out(oa), .obs_chan_b_out(ob),
		.obs_chan_a_oe_b_out(oea), .obs_chan_b_oe_b_out(oeb), .test_active_out(act));
	function automatic logic [11:0] parity(input logic [767:0] p);
		for (int n = 0; n < 12; n++) begin
			parity[n] = 1'h0;
			for (int i = 0; i < w[n]; i++) parity[n] ^= p[64*n+i];
		end
	endfunction : parity
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (2000) @(posedge mclk_in);
		failures++;
		print_verdict();
	end
	initial begin
		void'($urandom(44407));
		repeat (8) @(posedge mclk_in);
		rst_b_in <= 1'h1;
		start <= 1'h1;
		@(negedge mclk_in);
		chk(oea & oeb, 12'hfff);
		chk({11'h0, act}, 12'h0);
		for (int k = 0; k < 20 && ext_n !== 1'h1; k++) @(posedge mclk_in);
		repeat (2) @(negedge mclk_in);
		chk({11'h0, act}, 12'h1);
		for (int m = 0; m < 4; m++) begin
			ea = (m == 2) ? 12'hfff : 12'h0;
			eb = (m == 1) ? 12'hfff : 12'h0;
			for (int i = 0; i < 24; i++) begin
				@(posedge mclk_in);
				mode <= m[1:0];
				if (i < 2) pins <= i ? '1 : '0;
				else for (int k = 0; k < 24; k++) pins[32*k+:32] <= $urandom;
				@(negedge mclk_in);
				chk(res, parity(pins));
				if (m != 2) chk(oa, parity(pins));
				if (m != 1) chk(ob, parity(pins));
				chk(oea, ea);
				chk(oeb, eb);
			end
		end
		// strobe pairs matter only for real strobe polarity, not for this model
		for (int t = 0; t < 4; t++) begin
			@(posedge mclk_in);
			pins[t*64] <= !pins[t*64];
			@(negedge mclk_in);
			chk(res, parity(pins));
		end
		@(posedge mclk_in);
		rst_b_in <= 1'h0;
		@(posedge mclk_in);
		rst_b_in <= 1'h1;
		@(negedge mclk_in);
		chk(oea & oeb, 12'hfff);
		chk({11'h0, act}, 12'h0);
		@(negedge mclk_in);
		chk({11'h0, act}, 12'h1);
		@(posedge mclk_in);
		start <= 1'h0;
		repeat (3) @(negedge mclk_in);
		chk(oea & oeb, 12'hfff);
		print_verdict();
	end
endmodule : xor_tree_pin_test_bench
